//--- verilog/handshaking_digital_port.sv
// register front end, grouping and interrupt for the handshaking digital ports
module handshaking_digital_port #(
	parameter int NUM_PORTS = dio_pkg::NUM_PORTS,
	parameter logic [4*dio_pkg::NUM_PORTS-1:0] PORT_LINES = 16'h8888,
	parameter logic [dio_pkg::NUM_PORTS-1:0] FIXED_IN = 4'h0,
	parameter logic [dio_pkg::NUM_PORTS-1:0] FIXED_OUT = 4'h0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [dio_pkg::ADDR_W-1:0] addr,
	input wire logic [dio_pkg::DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [dio_pkg::DATA_W-1:0] rdata,
	// interrupt
	output logic irq,
	// port lines
	input wire logic [dio_pkg::LINE_W*NUM_PORTS-1:0] pin_in,
	output logic [dio_pkg::LINE_W*NUM_PORTS-1:0] pin_out,
	output logic [dio_pkg::LINE_W*NUM_PORTS-1:0] pin_oe,
	// handshake lines, one pair per port
	input wire logic [NUM_PORTS-1:0] req_in,
	output logic [NUM_PORTS-1:0] ack_out
);
	localparam int LW = dio_pkg::LINE_W;

	logic [NUM_PORTS-1:0] dir_q, dir_d, mode_q, mode_d, mask_q, mask_d;
	logic [NUM_PORTS-1:0] stat_q, stat_d, done_prev_q, done_prev_d;
	logic grp_q, grp_d, irq_q, irq_d;
	logic [dio_pkg::DATA_W-1:0] rdata_q, rdata_d;

	logic [NUM_PORTS-1:0] ch_wr, ch_rd, ch_dir, ch_mode, ch_req, ch_done;
	logic [LW*NUM_PORTS-1:0] ch_wdata, ch_rval;
	logic wr_grp, rd_grp;

	assign wr_grp = wr_stb && (addr == dio_pkg::OFS_GROUP_DATA);
	assign rd_grp = rd_stb && (addr == dio_pkg::OFS_GROUP_DATA);

	genvar i;
	generate
		for (i = 0; i < NUM_PORTS; i++) begin : g_port
			localparam logic [7:0] OFS =
				8'(dio_pkg::OFS_DATA_BASE + dio_pkg::PORT_STRIDE * 8'(i));
			localparam bit IN_GRP = (i < 2);
			logic own_wr, own_rd, grouped;

			assign own_wr = wr_stb && (addr == OFS);
			assign own_rd = rd_stb && (addr == OFS);
			// port 1 follows port 0 while the pair is grouped
			assign grouped = grp_q && IN_GRP;
			assign ch_wr[i] = own_wr || (grouped && wr_grp);
			assign ch_rd[i] = own_rd || (grouped && rd_grp);
			assign ch_wdata[LW*i +: LW] = (grouped && wr_grp) ?
				wdata[LW*i +: LW] : wdata[LW-1:0];
			assign ch_dir[i] = grouped ? dir_q[0] : dir_q[i];
			assign ch_mode[i] = grouped ? mode_q[0] : mode_q[i];
			assign ch_req[i] = grouped ? req_in[0] : req_in[i];

			port_channel #(
				.LINES(int'(PORT_LINES[4*i +: 4])),
				.FIXED_IN(FIXED_IN[i]),
				.FIXED_OUT(FIXED_OUT[i])
			) u_chan (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.dir_out(ch_dir[i]),
				.latched(ch_mode[i]),
				.wr(ch_wr[i]),
				.wdata(ch_wdata[LW*i +: LW]),
				.rd(ch_rd[i]),
				.rd_val(ch_rval[LW*i +: LW]),
				.done(ch_done[i]),
				.req(ch_req[i]),
				.pin_in(pin_in[LW*i +: LW]),
				.pin_out(pin_out[LW*i +: LW]),
				.pin_oe(pin_oe[LW*i +: LW]),
				.ack(ack_out[i])
			);
		end
	endgenerate

	// configuration, status and interrupt next values
	always_comb begin
		dir_d = dir_q;
		mode_d = mode_q;
		mask_d = mask_q;
		grp_d = grp_q;
		if (wr_stb) begin
			case (addr)
				dio_pkg::OFS_DIR: dir_d = wdata[NUM_PORTS-1:0];
				dio_pkg::OFS_MODE: mode_d = wdata[NUM_PORTS-1:0];
				dio_pkg::OFS_MASK: mask_d = wdata[NUM_PORTS-1:0];
				dio_pkg::OFS_GROUP: grp_d = wdata[dio_pkg::GROUP_PAIR_BIT];
				default: ;
			endcase
		end
		done_prev_d = ch_done;
		// a completion event in the clearing cycle stays set
		stat_d = stat_q;
		if (wr_stb && addr == dio_pkg::OFS_STATUS) begin
			stat_d = stat_q & ~wdata[NUM_PORTS-1:0];
		end
		stat_d = stat_d | (ch_done & ~done_prev_q);
		irq_d = |(stat_d & mask_d);
	end

	// read data stands from the cycle after the read strobe until the next clock with ce high
	always_comb begin
		rdata_d = '0;
		if (rd_stb) begin
			case (addr)
				dio_pkg::OFS_DIR: rdata_d[NUM_PORTS-1:0] = dir_q;
				dio_pkg::OFS_MODE: rdata_d[NUM_PORTS-1:0] = mode_q;
				dio_pkg::OFS_MASK: rdata_d[NUM_PORTS-1:0] = mask_q;
				dio_pkg::OFS_GROUP: rdata_d[dio_pkg::GROUP_PAIR_BIT] = grp_q;
				dio_pkg::OFS_STATUS: rdata_d[NUM_PORTS-1:0] = stat_q;
				dio_pkg::OFS_DONE: rdata_d[NUM_PORTS-1:0] = ch_done;
				dio_pkg::OFS_GROUP_DATA: begin
					if (grp_q) begin
						rdata_d[2*LW-1:0] = ch_rval[2*LW-1:0];
					end
				end
				default: begin
					for (int p = 0; p < NUM_PORTS; p++) begin
						if (addr == 8'(dio_pkg::OFS_DATA_BASE + dio_pkg::PORT_STRIDE * 8'(p))) begin
							rdata_d[LW-1:0] = ch_rval[LW*p +: LW];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dir_q <= dio_pkg::DIR_RESET;
			mode_q <= dio_pkg::MODE_RESET;
			mask_q <= dio_pkg::MASK_RESET;
			grp_q <= 1'b0;
			stat_q <= '0;
			done_prev_q <= '0;
			irq_q <= 1'b0;
			rdata_q <= '0;
		end else if (ce) begin
			dir_q <= dir_d;
			mode_q <= mode_d;
			mask_q <= mask_d;
			grp_q <= grp_d;
			stat_q <= stat_d;
			done_prev_q <= done_prev_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
endmodule : handshaking_digital_port

//--- shared/dio_pkg.sv
// constants shared by the handshaking digital port design
package dio_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LINE_W = 8;
	localparam int NUM_PORTS = 4;
	// byte offsets of the registers
	localparam logic [7:0] OFS_DATA_BASE = 8'h00;
	localparam logic [7:0] OFS_DIR = 8'h20;
	localparam logic [7:0] OFS_MODE = 8'h24;
	localparam logic [7:0] OFS_GROUP = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2C;
	localparam logic [7:0] OFS_MASK = 8'h30;
	localparam logic [7:0] OFS_GROUP_DATA = 8'h34;
	localparam logic [7:0] OFS_DONE = 8'h38;
	localparam logic [7:0] PORT_STRIDE = 8'h04;
	// field positions
	localparam int GROUP_PAIR_BIT = 0;
	// values after reset
	localparam logic [NUM_PORTS-1:0] DIR_RESET = 4'h0;
	localparam logic [NUM_PORTS-1:0] MODE_RESET = 4'h0;
	localparam logic [NUM_PORTS-1:0] MASK_RESET = 4'h0;
	localparam logic [LINE_W-1:0] LINE_RESET = 8'h00;
	// handshake pulse width
	localparam int CLK_PERIOD_NS = 10;
	localparam int ACK_PULSE_NS = 100;
	localparam int ACK_CYCLES = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_CNT_W = 8;
endpackage : dio_pkg

//--- verilog/port_channel.sv
// one eight-line digital port with optional latched handshaking
module port_channel #(
	parameter int LINES = 8,
	parameter bit FIXED_IN = 1'b0,
	parameter bit FIXED_OUT = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// configuration
	input wire logic dir_out,
	input wire logic latched,
	// host access
	input wire logic wr,
	input wire logic [dio_pkg::LINE_W-1:0] wdata,
	input wire logic rd,
	output logic [dio_pkg::LINE_W-1:0] rd_val,
	output logic done,
	// pins
	input wire logic req,
	input wire logic [dio_pkg::LINE_W-1:0] pin_in,
	output logic [dio_pkg::LINE_W-1:0] pin_out,
	output logic [dio_pkg::LINE_W-1:0] pin_oe,
	output logic ack
);
	localparam logic [dio_pkg::LINE_W-1:0] LINE_MASK =
		dio_pkg::LINE_W'((9'h001 << LINES) - 9'h001);
	localparam logic [dio_pkg::ACK_CNT_W-1:0] ACK_LOAD = dio_pkg::ACK_CNT_W'(dio_pkg::ACK_CYCLES);

	logic [dio_pkg::LINE_W-1:0] out_q, out_d, oe_q, oe_d, in_q, in_d, latch_q, latch_d;
	logic [dio_pkg::ACK_CNT_W-1:0] cnt_q, cnt_d;
	logic [dio_pkg::LINE_W-1:0] drv_q, drv_d;
	logic req_q, ack_q, ack_d, done_q, done_d;
	logic is_out, req_edge;

	// fixed ports ignore the direction setting
	assign is_out = FIXED_OUT | (~FIXED_IN & dir_out);
	assign req_edge = req & ~req_q;

	always_comb begin
		out_d = wr ? (wdata & LINE_MASK) : out_q;
		oe_d = is_out ? LINE_MASK : '0;
		// driven level kept in its own flop so the pin comes straight from a register
		drv_d = out_d & oe_d;
		in_d = pin_in & LINE_MASK;
		latch_d = latch_q;
		if (latched && !is_out && req_edge) begin
			latch_d = pin_in & LINE_MASK;
		end
		cnt_d = cnt_q;
		if (latched && is_out && wr) begin
			cnt_d = ACK_LOAD;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
		ack_d = (cnt_d != '0);
		// a new handshake in the clearing cycle is kept
		if (latched && req_edge) begin
			done_d = 1'b1;
		end else if (wr || rd) begin
			done_d = 1'b0;
		end else begin
			done_d = done_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_q <= dio_pkg::LINE_RESET;
			oe_q <= dio_pkg::LINE_RESET;
			drv_q <= dio_pkg::LINE_RESET;
			in_q <= dio_pkg::LINE_RESET;
			latch_q <= dio_pkg::LINE_RESET;
			cnt_q <= '0;
			req_q <= 1'b0;
			ack_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			out_q <= out_d;
			oe_q <= oe_d;
			drv_q <= drv_d;
			in_q <= in_d;
			latch_q <= latch_d;
			cnt_q <= cnt_d;
			req_q <= req;
			ack_q <= ack_d;
			done_q <= done_d;
		end
	end

	// output ports read back what they drive
	always_comb begin
		if (is_out) begin
			rd_val = out_q;
		end else if (latched) begin
			rd_val = latch_q;
		end else begin
			rd_val = in_q;
		end
	end

	assign pin_out = drv_q;
	assign pin_oe = oe_q;
	assign ack = ack_q;
	assign done = done_q;
endmodule : port_channel

//--- testbench/handshaking_digital_port_asserts.sv
// checker on the digital port pins and register port
module hdp_asserts #(parameter int NUM_PORTS = 4) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [31:0] rdata,
	input wire logic irq,
	// lines
	input wire logic [8*NUM_PORTS-1:0] pin_in,
	input wire logic [8*NUM_PORTS-1:0] pin_out,
	input wire logic [8*NUM_PORTS-1:0] pin_oe,
	input wire logic [NUM_PORTS-1:0] req_in,
	input wire logic [NUM_PORTS-1:0] ack_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_rdata_cause: assert property (rdata != 0 |-> $past(rd_stb && ce))
		else $error("read data without a read");
	chk_unmapped_zero: assert property ($past(rd_stb && addr == 8'h3C) |-> rdata == 0)
		else $error("unmapped read not zero");
	chk_oe_whole: assert property (pin_oe[7:0] inside {8'h00, 8'hFF})
		else $error("port enables split");
	chk_out_gated: assert property ((pin_out & ~pin_oe) == 0)
		else $error("level on undriven line");
	chk_ack_len: assert property ($rose(ack_out[0]) |-> ack_out[0] [*8] ##1 ack_out[0] [*2] ##1 !ack_out[0])
		else $error("handshake pulse length wrong");
	chk_ack_cause: assert property ($rose(ack_out[0]) |-> $past(wr_stb && ce && addr inside {8'h00, 8'h34}))
		else $error("handshake pulse without write");
	chk_irq_fall: assert property ($fell(irq) |-> $past(wr_stb && ce))
		else $error("interrupt dropped by itself");
	chk_oe_by_write: assert property ($changed(pin_oe) |-> $past(wr_stb, 2))
		else $error("direction changed without write");
	chk_out_by_write: assert property ($changed(pin_out) |-> $past(wr_stb) || $past(wr_stb, 2))
		else $error("line level changed without write");
	cover property ($rose(irq));
	cover property ($rose(ack_out[0]));
	cover property ($fell(irq));
endmodule : hdp_asserts

bind handshaking_digital_port hdp_asserts #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);

//--- testbench/ext_equip.sv
// far-side equipment: drives input lines and handshake requests
module ext_equip (
	// clock
	input wire logic clk,
	// device side
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	output logic [31:0] pin_in,
	output logic [3:0] req_in,
	// bench control
	input wire logic [31:0] drive,
	input wire logic [3:0] go
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] hold_q;
	// driven lines read back, the rest follow the equipment
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
	always_ff @(posedge clk) hold_q <= go;
	// request held high one cycle past go
	assign req_in = go | hold_q;
endmodule : ext_equip

//--- testbench/handshaking_digital_port_tb.sv
// self-checking bench for the handshaking digital port
module handshaking_digital_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, ce, wr_stb, rd_stb, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, pin_in, pin_out, pin_oe, drive, d;
	logic [3:0] req_in, ack_out, go;
	logic [15:0] lfsr = 16'h9283;
	logic [7:0] ra[5] = '{8'h20, 8'h24, 8'h30, 8'h38, 8'h3C};
	int num_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	handshaking_digital_port u_dut (.*);
	ext_equip u_eq (.*);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	task report_and_stop;
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		@(posedge clk);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask : rd
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		{wr_stb, rd_stb, addr, wdata, go, drive} = '0;
		rst = 1'b1;
		ce = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (ra[i]) rd(ra[i], 0);
		wr(8'h3C, 32'hFFFF_FFFF);
		ce <= 1'b0;
		wr(8'h20, 32'h0000_000F);
		ce <= 1'b1;
		rd(8'h20, 0);
		$display("done: reset");
		wr(8'h20, 32'h0000_000F);
		for (int p = 0; p < 4; p++) begin
			lfsr = nxt(lfsr);
			d = {lfsr, lfsr};
			wr(8'(4 * p), d);
			chk(32'(pin_out[8*p+:8]), 32'(d[7:0]));
			rd(8'(4 * p), 32'(d[7:0]));
		end
		chk(pin_oe, 32'hFFFF_FFFF);
		wr(8'h20, 0);
		lfsr = nxt(lfsr);
		drive <= {lfsr, ~lfsr};
		@(posedge clk);
		for (int p = 0; p < 4; p++) rd(8'(4 * p), 32'(drive[8*p+:8]));
		$display("done: plain");
		wr(8'h24, 1);
		wr(8'h30, 1);
		wr(8'h20, 1);
		wr(8'h00, 32'h0000_00A5);
		go <= 4'h1;
		#1 chk(32'(ack_out), 32'h1);
		@(posedge clk);
		go <= 4'h0;
		repeat (4) @(posedge clk);
		rd(8'h38, 1);
		chk(32'(irq), 1);
		wr(8'h2C, 1);
		#1 chk(32'(irq), 0);
		repeat (10) @(posedge clk);
		wr(8'h00, 0);
		rd(8'h38, 0);
		wr(8'h24, 3);
		drive <= 32'h0000_3C00;
		go <= 4'h2;
		repeat (2) @(posedge clk);
		go <= 4'h0;
		drive <= 32'h0000_C300;
		repeat (4) @(posedge clk);
		rd(8'h04, 32'h0000_003C);
		rd(8'h38, 0);
		$display("done: latched");
		wr(8'h24, 0);
		wr(8'h28, 1);
		wr(8'h34, 32'h0000_BEEF);
		chk(32'(pin_out[15:0]), 32'h0000_BEEF);
		rd(8'h34, 32'h0000_BEEF);
		$display("done: group");
		report_and_stop();
	end
endmodule : handshaking_digital_port_tb
